// >>> pkg/utlw_pkg.sv
// Functional notes
// - Each transfer descriptor is fetched as one fixed 32-byte block of eight words.
// - The transfer type is decoded from the isochronous bit, the token code and whether the descriptor was reached inside a queue.
// - A failed consistency check halts the walk at once and raises an interrupt.
// - The consistency interrupt reaches the output whatever the enable register holds.
// - Link word bits 31 to 4 become address bits 31 to 4 of the next object.
// - In a queue, link bit 2 picks breadth-first (0) or depth-first (1).
// - Depth-first continues with the next descriptor of the same queue.
// - Link bit 1 says whether the next object is a descriptor (0) or a queue head (1).
// - Link bit 0 set means the link address must not be followed.
// - A terminate bit met inside a queue ends that queue.
// - A terminate bit met outside a queue ends the frame.
// - A frame starts from its frame list entry and is skipped when its bit 0 is set.
package utlw_pkg;

  localparam logic [7:0] UTLW_OFF_CTRL   = 8'h00;
  localparam logic [7:0] UTLW_OFF_FRAME  = 8'h04;
  localparam logic [7:0] UTLW_OFF_STATUS = 8'h08;
  localparam logic [7:0] UTLW_OFF_INT_EN = 8'h0c;
  localparam logic [7:0] UTLW_OFF_CLR    = 8'h10;
  localparam logic [7:0] UTLW_OFF_CUR    = 8'h14;
  localparam logic [7:0] UTLW_OFF_TYPE   = 8'h18;

  localparam int unsigned UTLW_CTRL_START  = 0;
  localparam int unsigned UTLW_ST_DONE     = 0;
  localparam int unsigned UTLW_ST_SKIP     = 1;
  localparam int unsigned UTLW_ST_ERR      = 2;
  localparam int unsigned UTLW_ST_BUSY     = 3;
  localparam int unsigned UTLW_ST_HALT     = 4;
  localparam int unsigned UTLW_ST_W        = 3;
  localparam logic [2:0]  UTLW_ST_RESET    = 3'h0;
  localparam logic [2:0]  UTLW_INT_EN_RESET = 3'h0;
  localparam logic [31:0] UTLW_FRAME_RESET = 32'h0000_0000;

  localparam logic [2:0]  UTLW_TD_LAST   = 3'h7;
  localparam logic [2:0]  UTLW_QH_LAST   = 3'h1;
  localparam int unsigned UTLW_ISO_BIT   = 25;
  localparam logic [7:0]  UTLW_PID_IN    = 8'h69;
  localparam logic [7:0]  UTLW_PID_OUT   = 8'he1;
  localparam logic [7:0]  UTLW_PID_SETUP = 8'h2d;

  localparam logic [1:0]  UTLW_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  UTLW_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [27:0] next_object_address;
    logic        rsvd;
    logic        walk_order_select;
    logic        object_kind_select;
    logic        final_link_flag;
  } utlw_link_t;

  typedef enum logic [1:0] {
    UTLW_XT_CONTROL,
    UTLW_XT_BULK,
    UTLW_XT_INTERRUPT,
    UTLW_XT_ISO
  } utlw_xfer_t;

  typedef enum logic [1:0] {
    UTLW_FK_FRAME,
    UTLW_FK_TD,
    UTLW_FK_QH
  } utlw_kind_t;

endpackage : utlw_pkg

// >>> hw/utlw_walker.sv
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module utlw_walker
  import utlw_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             mem_rd_req_o,
  output logic [31:0]      mem_rd_addr_o,
  input  wire logic        mem_rd_ack_i,
  input  wire logic [31:0] mem_rd_data_i,
  output logic             irq_o
);

  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_EVAL} utlw_state_t;

  logic rst_s1_q, rst_s2_q, rst_n;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Bus slave state
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic        aw_full_q, w_full_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0]  w_strb_q;
  logic [1:0]  bresp_q, rresp_q;

  // Walker state
  utlw_state_t state_q;
  utlw_kind_t  kind_q;
  logic [2:0]  idx_q;
  logic [31:0] words_q [8];
  logic [31:0] addr_q, obj_q, frame_q, qh_head_q;
  logic        req_q, inq_q, halt_q, irq_q;
  logic [2:0]  st_q, en_q;
  utlw_xfer_t  xt_q;

  wire aw_hs = s_axi_awvalid_i & awready_q;
  wire w_hs  = s_axi_wvalid_i & wready_q;
  wire ar_hs = s_axi_arvalid_i & arready_q;
  wire wr_go = aw_full_q & w_full_q & ~bvalid_q;

  wire wr_ctrl  = wr_go & (aw_addr_q == UTLW_OFF_CTRL);
  wire wr_frame = wr_go & (aw_addr_q == UTLW_OFF_FRAME);
  wire wr_en    = wr_go & (aw_addr_q == UTLW_OFF_INT_EN);
  wire wr_clr   = wr_go & (aw_addr_q == UTLW_OFF_CLR);
  wire wr_ok    = wr_ctrl | wr_frame | wr_en | wr_clr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  wire [31:0] wmerged_frame = merge(frame_q, w_data_q, w_strb_q);
  wire [31:0] wmerged_en    = merge({29'h0, en_q}, w_data_q, w_strb_q);
  wire        start = wr_ctrl & w_strb_q[0] & w_data_q[UTLW_CTRL_START]
                      & (state_q == S_IDLE) & ~halt_q;

  // Read decode
  wire [31:0] st_view = {27'h0, halt_q, state_q != S_IDLE, st_q};
  wire        rd_ok   = s_axi_araddr_i inside {UTLW_OFF_CTRL, UTLW_OFF_FRAME,
                          UTLW_OFF_STATUS, UTLW_OFF_INT_EN, UTLW_OFF_CLR,
                          UTLW_OFF_CUR, UTLW_OFF_TYPE};
  wire [31:0] rd_val  = (s_axi_araddr_i == UTLW_OFF_FRAME)  ? frame_q :
                        (s_axi_araddr_i == UTLW_OFF_STATUS) ? st_view :
                        (s_axi_araddr_i == UTLW_OFF_INT_EN) ? {29'h0, en_q} :
                        (s_axi_araddr_i == UTLW_OFF_CUR)    ? obj_q :
                        (s_axi_araddr_i == UTLW_OFF_TYPE)   ? {30'h0, xt_q} : 32'h0;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= UTLW_RESP_OKAY;
    end else if (ce_i) begin
      if (aw_hs) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
        awready_q <= 1'b0;
      end
      if (w_hs) begin
        w_full_q  <= 1'b1;
        w_data_q  <= s_axi_wdata_i;
        w_strb_q  <= s_axi_wstrb_i;
        wready_q  <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? UTLW_RESP_OKAY : UTLW_RESP_SLVERR;
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
      end
      if (bvalid_q && s_axi_bready_i) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= UTLW_RESP_OKAY;
    end else if (ce_i) begin
      if (ar_hs) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_val;
        rresp_q   <= rd_ok ? UTLW_RESP_OKAY : UTLW_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready_i) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Fetch sequencing
  utlw_link_t w0, w1;
  assign w0 = utlw_link_t'(words_q[0]);
  assign w1 = utlw_link_t'(words_q[1]);

  wire [2:0] last_idx = (kind_q == UTLW_FK_TD) ? UTLW_TD_LAST :
                        (kind_q == UTLW_FK_QH) ? UTLW_QH_LAST : 3'h0;
  wire       got      = (state_q == S_FETCH) & req_q & mem_rd_ack_i;

  wire [7:0] pid     = words_q[2][7:0];
  wire       pid_ok  = pid inside {UTLW_PID_IN, UTLW_PID_OUT, UTLW_PID_SETUP};
  wire       td_bad  = w0.rsvd | ~pid_ok;
  wire       is_iso  = words_q[1][UTLW_ISO_BIT];

  utlw_xfer_t xt_d;
  always_comb begin
    if (is_iso)                    xt_d = UTLW_XT_ISO;
    else if (pid == UTLW_PID_SETUP) xt_d = UTLW_XT_CONTROL;
    else if (inq_q)                 xt_d = UTLW_XT_BULK;
    else                            xt_d = UTLW_XT_INTERRUPT;
  end

  // Decision on the fetched object
  utlw_link_t nxt;
  logic       ev_done, ev_skip, ev_err, ev_inq;
  always_comb begin
    nxt     = w0;
    ev_done = 1'b0;
    ev_skip = 1'b0;
    ev_err  = 1'b0;
    ev_inq  = inq_q;
    unique case (kind_q)
      UTLW_FK_FRAME: begin
        ev_skip = w0.final_link_flag;
        ev_inq  = 1'b0;
      end
      UTLW_FK_QH: begin
        if (w1.final_link_flag) begin
          nxt    = w0;
          ev_inq = 1'b0;
        end else begin
          nxt    = w1;
          ev_inq = 1'b1;
        end
      end
      UTLW_FK_TD: begin
        ev_err = td_bad;
        if (inq_q) begin
          if (!w0.final_link_flag && w0.walk_order_select) begin
            nxt = w0;
          end else begin
            nxt    = utlw_link_t'(qh_head_q);
            ev_inq = 1'b0;
          end
        end else begin
          ev_done = w0.final_link_flag;
        end
      end
      default: ;
    endcase
    if (!ev_skip && !ev_done && nxt.final_link_flag) begin
      ev_done = 1'b1;
    end
  end

  wire        ev_end  = ev_err | ev_skip | ev_done;
  wire [31:0] nxt_adr = {nxt.next_object_address, 4'h0};
  utlw_kind_t nxt_kind;
  assign nxt_kind = nxt.object_kind_select ? UTLW_FK_QH : UTLW_FK_TD;
  wire        eval    = (state_q == S_EVAL);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= S_IDLE;
      kind_q    <= UTLW_FK_FRAME;
      idx_q     <= 3'h0;
      addr_q    <= 32'h0;
      obj_q     <= 32'h0;
      req_q     <= 1'b0;
      inq_q     <= 1'b0;
      qh_head_q <= 32'h0;
      xt_q      <= UTLW_XT_CONTROL;
    end else if (ce_i) begin
      unique case (state_q)
        S_IDLE: begin
          if (start) begin
            state_q <= S_FETCH;
            kind_q  <= UTLW_FK_FRAME;
            idx_q   <= 3'h0;
            addr_q  <= {frame_q[31:2], 2'b00};
            obj_q   <= {frame_q[31:2], 2'b00};
            req_q   <= 1'b1;
            inq_q   <= 1'b0;
          end
        end
        S_FETCH: begin
          if (got) begin
            if (idx_q == last_idx) begin
              state_q <= S_EVAL;
              req_q   <= 1'b0;
            end else begin
              idx_q  <= idx_q + 3'h1;
              addr_q <= addr_q + 32'h4;
            end
          end
        end
        S_EVAL: begin
          if (kind_q == UTLW_FK_TD) xt_q <= xt_d;
          if (kind_q == UTLW_FK_QH) qh_head_q <= words_q[0];
          inq_q <= ev_inq;
          if (ev_end) begin
            state_q <= S_IDLE;
          end else begin
            state_q <= S_FETCH;
            kind_q  <= nxt_kind;
            idx_q   <= 3'h0;
            addr_q  <= nxt_adr;
            obj_q   <= nxt_adr;
            req_q   <= 1'b1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (ce_i && got) words_q[idx_q] <= mem_rd_data_i;
  end

  // Status, enables and interrupt
  wire [2:0] st_set = {eval & ev_err, eval & ev_skip, eval & ev_done & ~ev_err};
  wire [2:0] st_clr = wr_clr ? wmerged_en[2:0] & {3{1'b1}} & w_data_q[2:0] : 3'h0;
  wire [2:0] st_d   = (st_q & ~st_clr) | st_set;
  wire       irq_d  = |(st_d & en_q) | st_d[UTLW_ST_ERR];

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= UTLW_ST_RESET;
      en_q    <= UTLW_INT_EN_RESET;
      frame_q <= UTLW_FRAME_RESET;
      halt_q  <= 1'b0;
      irq_q   <= 1'b0;
    end else if (ce_i) begin
      st_q  <= st_d;
      irq_q <= irq_d;
      if (wr_en)    en_q    <= wmerged_en[2:0];
      if (wr_frame) frame_q <= wmerged_frame;
      halt_q <= st_d[UTLW_ST_ERR];
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;
  assign mem_rd_req_o    = req_q;
  assign mem_rd_addr_o   = addr_q;
  assign irq_o           = irq_q;

endmodule : utlw_walker

// >>> tb/utlw_mem_model.sv
`timescale 1ns/1ps
module utlw_mem_model (
  input  wire logic        clock_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  output logic             ack_o,
  output logic [31:0]      data_o
);
  // Schedule words, written by the bench
  logic [31:0] m [0:1023];
  logic [1:0]  wait_q;
  logic [31:0] last_q;
  initial begin
    ack_o  = 1'b0;
    data_o = 32'h0;
    wait_q = 2'h0;
    last_q = 32'h0;
  end
  // Varying latency; stale data is inverted outside the ack cycle
  always @(posedge clock_i) begin
    wait_q <= wait_q + 2'h1;
    ack_o  <= 1'b0;
    data_o <= ~last_q;
    if (req_i && !ack_o && wait_q != 2'h0) begin
      ack_o  <= 1'b1;
      data_o <= m[addr_i[11:2]];
      last_q <= m[addr_i[11:2]];
    end
  end
endmodule : utlw_mem_model

// >>> tb/utlw_walker_props.sv
`timescale 1ns/1ps
module utlw_walker_props
  import utlw_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        mem_rd_req_o,
  input wire logic [31:0] mem_rd_addr_o,
  input wire logic        mem_rd_ack_i,
  input wire logic        irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0] ra_q;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) ra_q <= 8'h00;
    else if (s_axi_arvalid_i && s_axi_arready_o) ra_q <= s_axi_araddr_i;
  end
  wire st_rd = s_axi_rvalid_o && (ra_q == UTLW_OFF_STATUS);
  sequence s_ar_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  sequence s_r_take;
    s_axi_rvalid_o && s_axi_rready_i;
  endsequence
  chk_r_answer: assert property (s_ar_take |=> s_axi_rvalid_o)
    else $error("read answer not one cycle after address");
  chk_r_single: assert property (s_r_take |=> !s_axi_rvalid_o)
    else $error("read data repeated");
  chk_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address open while data pending");
  chk_aw_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
    else $error("write address open while response pending");
  chk_slverr_rd: assert property (s_axi_rvalid_o && ra_q > UTLW_OFF_TYPE
    |-> s_axi_rresp_o == UTLW_RESP_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  chk_fetch_word: assert property (mem_rd_req_o |-> mem_rd_addr_o[1:0] == 2'h0)
    else $error("fetch address not word aligned");
  chk_addr_hold: assert property (mem_rd_req_o && !mem_rd_ack_i
    |=> mem_rd_req_o && $stable(mem_rd_addr_o))
    else $error("fetch request dropped or moved");
  chk_err_irq: assert property (st_rd && s_axi_rdata_o[UTLW_ST_ERR] |-> irq_o)
    else $error("error status without interrupt");
  chk_halt_stop: assert property (st_rd && s_axi_rdata_o[UTLW_ST_HALT] |-> !mem_rd_req_o)
    else $error("fetch while halted");
  chk_done_idle: assert property (st_rd && s_axi_rdata_o[UTLW_ST_DONE]
    && !s_axi_rdata_o[UTLW_ST_BUSY] |-> !mem_rd_req_o)
    else $error("fetch after frame done");
endmodule : utlw_walker_props
bind utlw_walker utlw_walker_props u_props (.clock_i, .rstn_i, .s_axi_awready_o,
  .s_axi_bvalid_o, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
  .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .mem_rd_req_o, .mem_rd_addr_o,
  .mem_rd_ack_i, .irq_o);

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import utlw_pkg::*;
  logic clock_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire mem_rd_req_o, mem_rd_ack_i, irq_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o, mem_rd_addr_o, mem_rd_data_i;
  int err_total = 0, check_count = 0, cyc = 0, fetches = 0, f0;
  int seed = 32'h6692519c;
  logic [31:0] rd, r, a2;
  logic [1:0] resp;
  logic [7:0] pid;
  logic [7:0] pids [3] = '{UTLW_PID_IN, UTLW_PID_OUT, UTLW_PID_SETUP};
  utlw_walker DUT (.clock_i, .rstn_i, .ce_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .mem_rd_req_o, .mem_rd_addr_o, .mem_rd_ack_i, .mem_rd_data_i, .irq_o);
  utlw_mem_model mem (.clock_i(clock_i), .req_i(mem_rd_req_o), .addr_i(mem_rd_addr_o),
    .ack_o(mem_rd_ack_i), .data_o(mem_rd_data_i));
  initial forever #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (ce_i && mem_rd_req_o && mem_rd_ack_i) fetches++;
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    forever begin
      @(posedge clock_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o) begin
        resp = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    forever begin
      @(posedge clock_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o) begin
        rd   = s_axi_rdata_o;
        resp = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        break;
      end
    end
  endtask : rd_reg
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a);
    chk($sformatf("reg %h", a), e, rd);
    chk("rresp", UTLW_RESP_OKAY, resp);
  endtask : rc
  task automatic chk_irq(input logic e);
    repeat (3) @(posedge clock_i);
    chk("irq", e, irq_o);
  endtask : chk_irq
  // Eight random words, then the fields the walker decodes
  task automatic put_td(input int a, input logic [31:0] lnk, input logic iso);
    for (int i = 0; i < 8; i++) mem.m[a/4+i] = $random(seed);
    mem.m[a/4] = lnk;
    mem.m[a/4+1][UTLW_ISO_BIT] = iso;
    mem.m[a/4+2][7:0] = pid;
  endtask : put_td
  task automatic run_frame;
    wr(UTLW_OFF_CLR, 32'h7);
    f0 = fetches;
    wr(UTLW_OFF_CTRL, 32'h1);
    do rd_reg(UTLW_OFF_STATUS);
    while (rd[2:0] == 3'h0);
  endtask : run_frame
  function automatic logic [31:0] exp_type(input logic iso, input logic [7:0] p, input logic q);
    if (iso) return {30'h0, UTLW_XT_ISO};
    if (p == UTLW_PID_SETUP) return {30'h0, UTLW_XT_CONTROL};
    return q ? {30'h0, UTLW_XT_BULK} : {30'h0, UTLW_XT_INTERRUPT};
  endfunction : exp_type
  initial begin
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rc(UTLW_OFF_STATUS, {29'h0, UTLW_ST_RESET});
    rc(UTLW_OFF_INT_EN, {29'h0, UTLW_INT_EN_RESET});
    rc(UTLW_OFF_FRAME, UTLW_FRAME_RESET);
    rd_reg(8'h40);
    chk("rresp", UTLW_RESP_SLVERR, resp);
    wr(8'h44, $random(seed));
    chk("bresp", UTLW_RESP_SLVERR, resp);
    wr(UTLW_OFF_INT_EN, 32'h7);
    // Only byte 1 of the entry address is written
    s_axi_wstrb_i <= 4'h2;
    wr(UTLW_OFF_FRAME, 32'haabb0300);
    s_axi_wstrb_i <= 4'hf;
    rc(UTLW_OFF_FRAME, 32'h300);
    wr(UTLW_OFF_FRAME, 32'h3f0);
    rc(UTLW_OFF_FRAME, 32'h3f0);
    mem.m[252] = ($random(seed) & 32'hfffffff3) | 32'h1;
    run_frame;
    chk("skip", 32'h2, rd & 32'h7);
    chk("fetch", 1, fetches - f0);
    chk_irq(1'b1);
    wr(UTLW_OFF_INT_EN, 32'h0);
    chk_irq(1'b0);
    wr(UTLW_OFF_INT_EN, 32'h7);
    chk_irq(1'b1);
    wr(UTLW_OFF_CLR, 32'h7);
    chk_irq(1'b0);
    wr(UTLW_OFF_FRAME, 32'h0);
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      pid = pids[r[9:8] % 3];
      a2 = 32'h200 | {24'h0, r[7:4], 4'h0};
      mem.m[0] = 32'h100;
      // Reserved bit 3 stays zero in software-built links
      put_td(32'h100, k[0] ? a2 | {r[0], 2'b00} : {r[31:4], 1'b0, r[2:1], 1'b1}, r[10]);
      put_td(a2, {r[31:4], 4'h1}, r[10]);
      run_frame;
      chk("done", 32'h1, rd & 32'h7);
      chk("fetch", k[0] ? 17 : 9, fetches - f0);
      rc(UTLW_OFF_CUR, k[0] ? a2 : 32'h100);
      rc(UTLW_OFF_TYPE, exp_type(r[10], pid, 1'b0));
    end
    // Last two-descriptor chain again, frozen mid-walk by the clock enable
    wr(UTLW_OFF_CLR, 32'h7);
    f0 = fetches;
    wr(UTLW_OFF_CTRL, 32'h1);
    repeat (4) @(posedge clock_i);
    ce_i <= 1'b0;
    @(posedge clock_i);
    r = mem_rd_addr_o;
    repeat (20) @(posedge clock_i);
    chk("freeze addr", r, mem_rd_addr_o);
    ce_i <= 1'b1;
    do rd_reg(UTLW_OFF_STATUS);
    while (rd[2:0] == 3'h0);
    chk("done", 32'h1, rd & 32'h7);
    chk("fetch", 17, fetches - f0);
    rc(UTLW_OFF_CUR, a2);
    for (int vf = 0; vf < 2; vf++) begin
      r = $random(seed);
      pid = pids[r[9:8] % 3];
      mem.m[0] = 32'h42;
      mem.m[16] = {r[31:4], 4'h1};
      mem.m[17] = 32'h100;
      put_td(32'h100, 32'h200 | (vf << 2), r[10]);
      put_td(32'h200, 32'h1, r[10]);
      run_frame;
      chk("done", 32'h1, rd & 32'h7);
      chk("fetch", vf ? 19 : 11, fetches - f0);
      rc(UTLW_OFF_TYPE, exp_type(r[10], pid, 1'b1));
    end
    for (int j = 0; j < 2; j++) begin
      pid = j ? UTLW_PID_IN : 8'h00;
      mem.m[0] = 32'h100;
      put_td(32'h100, j ? 32'h208 : 32'h1, 1'b0);
      run_frame;
      chk("err", 32'h14, rd & 32'h1c);
      f0 = fetches;
      wr(UTLW_OFF_CTRL, 32'h1);
      wr(UTLW_OFF_INT_EN, 32'h0);
      chk_irq(1'b1);
      chk("halt", 0, fetches - f0);
      wr(UTLW_OFF_INT_EN, 32'h7);
      wr(UTLW_OFF_CLR, 32'h7);
      rc(UTLW_OFF_STATUS, 32'h0);
    end
    stop_test();
  end
endmodule : tb
